// ### rtl/door_fault_pkg.sv
// constants, codes and state encodings of the door fault status manager.
// assumes a 40 MHz core clock; all figures are shared by the rtl files.
package door_fault_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned MOVE_MAX_S = 65;
   localparam int unsigned MOVE_MAX_MS = MOVE_MAX_S * 1000;
   localparam int unsigned PROT_S = 5;
   localparam int unsigned PROT_MS = PROT_S * 1000;
   localparam logic [1:0] INIT_LOAD = 2'h3;

   // ----------------------------------------------------------------
   // fault vector layout, lowest index has highest display priority
   // ----------------------------------------------------------------
   localparam int F_SYS = 0;
   localparam int F_MOVE = 1;
   localparam int F_MOTOR = 2;
   localparam int F_PULSE = 3;
   localparam int F_SAFETY = 4;
   localparam int F_OVERCUR = 5;
   localparam int F_MASS = 11;
   localparam int NUM_FAULTS = 12;
   localparam int NUM_HW = 10;
   localparam int ACK_BIT = 7;
   localparam logic [3:0] FBLK_FN_ACK = 4'h3;

   // ----------------------------------------------------------------
   // display codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_OK = 8'h30;
   localparam logic [7:0] CODE_4 = 8'h34;
   localparam logic [7:0] CODE_5 = 8'h35;
   localparam logic [7:0] CODE_6 = 8'h36;
   localparam logic [7:0] CODE_7 = 8'h37;
   localparam logic [7:0] CODE_P = 8'h50;
   localparam logic [7:0] CODE_Y = 8'h79;
   localparam logic [7:0] CODE_NOPAR = 8'h5f;
   localparam logic [7:0] CODE_A = 8'h61;
   localparam logic [7:0] CODE_U = 8'h55;
   localparam logic [7:0] FAULT_CODE [NUM_FAULTS] = '{
      8'h31, 8'h34, 8'h35, 8'h37, 8'h38, 8'h39,
      8'h45, 8'h46, 8'h6e, 8'h4c, 8'h74, 8'h55};

   localparam logic [1:0] CLS_OK = 2'h0;
   localparam logic [1:0] CLS_INFO = 2'h1;
   localparam logic [1:0] CLS_ALARM = 2'h2;
   localparam logic [1:0] CLS_FAULT = 2'h3;

   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_FAULT = 4'h2,
      ST_WAIT = 4'h4,
      ST_RESET = 4'h8
   } mgr_state_t;

endpackage : door_fault_pkg

// ### rtl/pin_sync.sv
// two flip-flop synchroniser for a bundle of pin levels.
// assumes each bit is a slow level; multi-bit fields must be held stable.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int W = 8
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // only the second stage is visible to the rest of the block
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule : pin_sync
`default_nettype wire

// ### rtl/door_fault_mgr.sv
// fault, alarm and info status manager of the door drive controller.
// assumes pin levels are asynchronous; control word and function block
// outputs come from logic on core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module door_fault_mgr #(
   parameter int DW = 4,
   parameter int unsigned TICK_CYC = door_fault_pkg::TICK_CYC,
   parameter int unsigned MOVE_MS = door_fault_pkg::MOVE_MAX_MS,
   parameter int unsigned PROT_MS = door_fault_pkg::PROT_MS
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic move_active_i,
   input wire logic [3:0] motor_type_i,
   input wire logic [3:0] nv_type_i,
   input wire logic nv_valid_i,
   input wire logic learn_run_i,
   input wire logic learn_ok_i,
   input wire logic learn_err_i,
   input wire logic params_valid_i,
   input wire logic [9:0] hw_fault_i,
   input wire logic hold_extend_i,
   input wire logic comm_timeout_i,
   input wire logic [1:0] disc_err_i,
   input wire logic [DW-1:0] disc_block_zero_i,
   input wire logic [DW-1:0] disc_block_two_i,
   input wire logic obstruct_close_i,
   input wire logic ack_term_i,
   input wire logic free_fblk_out_i,
   input wire logic [3:0] free_fblk_fn_i,
   input wire logic [15:0] first_control_word_i,
   output logic [7:0] status_code_o,
   output logic [1:0] status_class_o,
   output logic fault_latched_o,
   output logic reset_wait_o,
   output logic ctrl_reset_o
);

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   localparam int SW = 30 + 2 * DW;
   logic [SW-1:0] pins;
   logic [SW-1:0] pins_s;

   assign pins = {move_active_i, motor_type_i, nv_type_i, nv_valid_i,
                  learn_run_i, learn_ok_i, learn_err_i, params_valid_i,
                  hw_fault_i, hold_extend_i, comm_timeout_i, disc_err_i,
                  disc_block_zero_i, disc_block_two_i, obstruct_close_i,
                  ack_term_i};

   pin_sync #(.W(SW)) u_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pin_i(pins),
      .sync_o(pins_s)
   );

   wire move_s = pins_s[SW-1];
   wire [3:0] mtype_s = pins_s[SW-2 -: 4];
   wire [3:0] nvt_s = pins_s[SW-6 -: 4];
   wire nvv_s = pins_s[SW-10];
   wire lrun_s = pins_s[SW-11];
   wire lok_s = pins_s[SW-12];
   wire lerr_s = pins_s[SW-13];
   wire pval_s = pins_s[SW-14];
   wire [9:0] hw_s = pins_s[SW-15 -: 10];
   wire hold_s = pins_s[SW-25];
   wire comm_s = pins_s[SW-26];
   wire [1:0] derr_s = pins_s[SW-27 -: 2];
   wire [DW-1:0] d0_s = pins_s[2*DW+1 -: DW];
   wire [DW-1:0] d1_s = pins_s[DW+1 -: DW];
   wire obst_s = pins_s[1];
   wire term_s = pins_s[0];

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   logic [15:0] tick_cnt_ff;
   logic tick_ff;
   wire tick_wrap = tick_cnt_ff == 16'(TICK_CYC - 1);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= tick_wrap ? 16'h0000 : tick_cnt_ff + 16'h0001;
         tick_ff <= tick_wrap;
      end
   end

   // ----------------------------------------------------------------
   // movement duration, counts whole ticks so the limit is never early
   // ----------------------------------------------------------------
   logic [16:0] move_ms_ff;
   wire move_over = move_ms_ff > 17'(MOVE_MS);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         move_ms_ff <= '0;
      end else if (!move_s) begin
         move_ms_ff <= '0;
      end else if (tick_ff && !move_over) begin
         move_ms_ff <= move_ms_ff + 17'h00001;
      end
   end

   // ----------------------------------------------------------------
   // learned motor type, loaded from storage once synchronisers settle
   // ----------------------------------------------------------------
   logic [1:0] init_cnt_ff;
   logic init_done_ff;
   logic [3:0] learned_type_ff;
   logic learned_valid_ff;
   logic lok_ff;
   logic lrun_ff;
   wire learn_ok_rise = lok_s && !lok_ff;
   wire learn_start = lrun_s && !lrun_ff;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         init_cnt_ff <= '0;
         init_done_ff <= 1'b0;
         learned_type_ff <= '0;
         learned_valid_ff <= 1'b0;
         lok_ff <= 1'b0;
         lrun_ff <= 1'b0;
      end else begin
         lok_ff <= lok_s;
         lrun_ff <= lrun_s;
         if (!init_done_ff) begin
            init_cnt_ff <= init_cnt_ff + 2'h1;
         end
         if (!init_done_ff && init_cnt_ff == door_fault_pkg::INIT_LOAD) begin
            init_done_ff <= 1'b1;
            learned_type_ff <= nvt_s;
            learned_valid_ff <= nvv_s;
         end else if (init_done_ff && learn_ok_rise) begin
            learned_type_ff <= mtype_s;
            learned_valid_ff <= 1'b1;
         end
      end
   end

   wire motor_undef = init_done_ff && !learned_valid_ff;
   wire motor_new = init_done_ff && learned_valid_ff
                    && mtype_s != learned_type_ff;

   // ----------------------------------------------------------------
   // acknowledgement sources
   // ----------------------------------------------------------------
   logic ack_any_ff;
   wire fblk_ack = free_fblk_out_i
                   && free_fblk_fn_i == door_fault_pkg::FBLK_FN_ACK;
   wire cw_ack = first_control_word_i[door_fault_pkg::ACK_BIT];
   wire ack_any = term_s || fblk_ack || cw_ack;
   // edge only, so a held request cannot swallow later faults
   wire ack_req = ack_any && !ack_any_ff;

   // ----------------------------------------------------------------
   // fault latch and sequence
   // ----------------------------------------------------------------
   logic [door_fault_pkg::NUM_FAULTS-1:0] fault_ff;
   door_fault_pkg::mgr_state_t state_ff;
   door_fault_pkg::mgr_state_t nxt_state;
   logic [15:0] prot_ms_ff;
   logic ctrl_reset_ff;
   logic [door_fault_pkg::NUM_FAULTS-1:0] fault_src;

   assign fault_src = {hw_s[9:1], motor_undef, move_over, hw_s[0]};

   wire fault_any = |fault_ff;
   wire ack_take = state_ff == door_fault_pkg::ST_FAULT && ack_req;
   wire prot_done = state_ff == door_fault_pkg::ST_WAIT && tick_ff
                    && prot_ms_ff == 16'(PROT_MS);

   always_comb begin
      case (state_ff)
         door_fault_pkg::ST_RUN:
            nxt_state = fault_any ? door_fault_pkg::ST_FAULT
                                  : door_fault_pkg::ST_RUN;
         door_fault_pkg::ST_FAULT:
            nxt_state = ack_take ? door_fault_pkg::ST_WAIT
                                 : door_fault_pkg::ST_FAULT;
         door_fault_pkg::ST_WAIT:
            nxt_state = prot_done ? door_fault_pkg::ST_RESET
                                  : door_fault_pkg::ST_WAIT;
         default:
            nxt_state = door_fault_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_ff <= '0;
         state_ff <= door_fault_pkg::ST_RUN;
         prot_ms_ff <= '0;
         ctrl_reset_ff <= 1'b0;
         ack_any_ff <= 1'b0;
      end else begin
         ack_any_ff <= ack_any;
         // a fault still present re-latches over the clear
         fault_ff <= (ack_take ? '0 : fault_ff) | fault_src;
         state_ff <= nxt_state;
         if (state_ff != door_fault_pkg::ST_WAIT) begin
            prot_ms_ff <= '0;
         end else if (tick_ff) begin
            prot_ms_ff <= prot_ms_ff + 16'h0001;
         end
         ctrl_reset_ff <= prot_done;
      end
   end

   // ----------------------------------------------------------------
   // alarms
   // ----------------------------------------------------------------
   logic learn_err_ff;
   logic [1:0] alarm_disc_ff;
   wire [DW-1:0] disc_in [2];

   assign disc_in[0] = d0_s;
   assign disc_in[1] = d1_s;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         learn_err_ff <= 1'b0;
      end else begin
         // cleared by a new learn run, set wins
         learn_err_ff <= (learn_err_ff && !learn_start)
                         || (lrun_s && lerr_s);
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_disc
      wire agree = disc_in[g] == '0 || disc_in[g] == '1;
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            alarm_disc_ff[g] <= 1'b0;
         end else begin
            alarm_disc_ff[g] <= (alarm_disc_ff[g] && !agree)
                                || derr_s[g];
         end
      end
   end

   // ----------------------------------------------------------------
   // status code selection
   // ----------------------------------------------------------------
   logic [7:0] fault_code;

   always_comb begin
      fault_code = door_fault_pkg::CODE_OK;
      for (int i = door_fault_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
         if (fault_ff[i]) begin
            fault_code = door_fault_pkg::FAULT_CODE[i];
         end
      end
   end

   wire alarm_any = hold_s || motor_new || learn_err_ff || comm_s
                    || !pval_s || (|alarm_disc_ff);
   wire [7:0] alarm_code =
      hold_s ? door_fault_pkg::CODE_4 :
      motor_new ? door_fault_pkg::CODE_5 :
      learn_err_ff ? door_fault_pkg::CODE_P :
      comm_s ? door_fault_pkg::CODE_Y :
      !pval_s ? door_fault_pkg::CODE_NOPAR :
      door_fault_pkg::CODE_A;
   wire [7:0] nxt_code = fault_any ? fault_code :
                         alarm_any ? alarm_code :
                         obst_s ? door_fault_pkg::CODE_6 :
                         door_fault_pkg::CODE_OK;
   wire [1:0] nxt_class = fault_any ? door_fault_pkg::CLS_FAULT :
                          alarm_any ? door_fault_pkg::CLS_ALARM :
                          obst_s ? door_fault_pkg::CLS_INFO :
                          door_fault_pkg::CLS_OK;

   logic [7:0] code_ff;
   logic [1:0] class_ff;
   logic latched_ff;
   logic wait_ff;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         code_ff <= door_fault_pkg::CODE_OK;
         class_ff <= door_fault_pkg::CLS_OK;
         latched_ff <= 1'b0;
         wait_ff <= 1'b0;
      end else begin
         code_ff <= nxt_code;
         class_ff <= nxt_class;
         latched_ff <= fault_any;
         wait_ff <= nxt_state == door_fault_pkg::ST_WAIT;
      end
   end

   assign status_code_o = code_ff;
   assign status_class_o = class_ff;
   assign fault_latched_o = latched_ff;
   assign reset_wait_o = wait_ff;
   assign ctrl_reset_o = ctrl_reset_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   move_limit_a: assert property (
      move_over |=> fault_ff[door_fault_pkg::F_MOVE])
      else $error("long movement did not latch its fault");
   motor_undef_a: assert property (
      motor_undef |=> fault_ff[door_fault_pkg::F_MOTOR]
                      && fault_ff[door_fault_pkg::F_MOTOR])
      else $error("unlearned motor did not latch its fault");
   pulse_code_a: assert property (
      fault_ff == 12'h008 |=> status_code_o == door_fault_pkg::CODE_7)
      else $error("pulse generator fault shows wrong code");
   mass_code_a: assert property (
      fault_ff == 12'h800 |=> status_code_o == door_fault_pkg::CODE_U)
      else $error("moving mass fault shows wrong code");
   comm_alarm_a: assert property (
      comm_s && !fault_any && !hold_s && !motor_new && !learn_err_ff
      |=> status_code_o == door_fault_pkg::CODE_Y)
      else $error("master timeout alarm not shown");
   disc_hold_a: assert property (
      alarm_disc_ff[0] && d0_s != '0 && d0_s != '1 |=> alarm_disc_ff[0])
      else $error("discrepancy alarm dropped while inputs disagree");
   fault_hold_a: assert property (
      fault_ff[door_fault_pkg::F_SYS] && !ack_take
      |=> fault_ff[door_fault_pkg::F_SYS])
      else $error("fault dropped without acknowledgement");
   prot_reset_a: assert property (
      $rose(ctrl_reset_ff) |-> $past(state_ff) == door_fault_pkg::ST_WAIT
                               && $past(prot_ms_ff) == 16'(PROT_MS)
                               ##1 !ctrl_reset_ff)
      else $error("controller reset without full protection time");
   cw_ack_a: assert property (
      state_ff == door_fault_pkg::ST_FAULT && cw_ack && !ack_any_ff
      |=> state_ff == door_fault_pkg::ST_WAIT ##1 reset_wait_o)
      else $error("control word acknowledgement not taken");
   term_ack_a: assert property (
      state_ff == door_fault_pkg::ST_FAULT && term_s && !ack_any_ff
      |=> state_ff == door_fault_pkg::ST_WAIT)
      else $error("terminal acknowledgement not taken");
   sys_fault_a: assert property (
      hw_s[0] |=> fault_ff[door_fault_pkg::F_SYS] ##1 status_class_o
                  == door_fault_pkg::CLS_FAULT)
      else $error("system error not reported as fault");
   fault_first_a: assert property (
      fault_any && alarm_any |=> status_class_o == door_fault_pkg::CLS_FAULT)
      else $error("alarm shown over a latched fault");

endmodule : door_fault_mgr
`default_nettype wire

// ### verif/ack_source.sv
// acknowledge sources seen by the fault manager: fieldbus master control
// word, terminal pin and function block. assumes go_i is a one-cycle
// request driven at the rising edge of core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module ack_source (
   input wire logic core_clk_i,
   input wire logic go_i,
   input wire logic [1:0] src_i,
   output logic [15:0] first_control_word_o,
   output logic ack_term_o,
   output logic free_fblk_out_o,
   output logic [3:0] free_fblk_fn_o
);
   int hold = 0;
   logic [1:0] src = 2'h0;
   logic act;

   // -------------------------------------------------------------------
   // request hold
   // -------------------------------------------------------------------
   // held four cycles so the terminal pin survives its synchroniser
   always @(posedge core_clk_i) begin
      if (go_i) begin
         hold <= 4;
         src <= src_i;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end
   end
   assign act = hold > 0;

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   // control bits 0 and 2 stay set to show that only bit 7 acknowledges
   assign first_control_word_o = {8'h00, act && src == 2'h0,
                                  7'h05};
   assign ack_term_o = act && src == 2'h1;
   // source 3 pulses the block under another function, which must be refused
   assign free_fblk_out_o = act && src[1];
   assign free_fblk_fn_o = src == 2'h3 ? 4'h0 : door_fault_pkg::FBLK_FN_ACK;
endmodule : ack_source
`default_nettype wire

// ### verif/door_fault_mgr_bench.sv
// self-checking bench of the door fault status manager.
// assumes shortened tick and time parameters; expectations use them.
`timescale 1ns/10ps
`default_nettype none
module door_fault_mgr_bench;
   localparam int unsigned TK = 4;
   localparam int unsigned MV = 5;
   localparam int unsigned PR = 3;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic move, nv_valid, learn_run, learn_ok, learn_err, params_valid;
   logic hold_ext, comm_to, obstruct, go;
   logic [3:0] motor_type, nv_type, blk_zero, blk_two, fblk_fn;
   logic [9:0] hw_fault;
   logic [1:0] disc_err, src, cls;
   logic [15:0] cw;
   logic [7:0] code;
   logic ack_term, fblk_out, latched, rwait, creset;
   int fail_count = 0;
   int check_count = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   ack_source far (.core_clk_i(core_clk_i), .go_i(go), .src_i(src),
      .first_control_word_o(cw), .ack_term_o(ack_term),
      .free_fblk_out_o(fblk_out), .free_fblk_fn_o(fblk_fn));

   door_fault_mgr #(.TICK_CYC(TK), .MOVE_MS(MV), .PROT_MS(PR)) dut (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .move_active_i(move),
      .motor_type_i(motor_type), .nv_type_i(nv_type),
      .nv_valid_i(nv_valid), .learn_run_i(learn_run),
      .learn_ok_i(learn_ok), .learn_err_i(learn_err),
      .params_valid_i(params_valid), .hw_fault_i(hw_fault),
      .hold_extend_i(hold_ext), .comm_timeout_i(comm_to),
      .disc_err_i(disc_err), .disc_block_zero_i(blk_zero),
      .disc_block_two_i(blk_two), .obstruct_close_i(obstruct),
      .ack_term_i(ack_term), .free_fblk_out_i(fblk_out),
      .free_fblk_fn_i(fblk_fn), .first_control_word_i(cw),
      .status_code_o(code), .status_class_o(cls),
      .fault_latched_o(latched), .reset_wait_o(rwait),
      .ctrl_reset_o(creset));

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cyc

   // sample 1 ns after the edge so registered outputs have landed
   task automatic look(input int n);
      cyc(n);
      #1;
   endtask : look

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic see_st(input int n, input logic [7:0] c,
                         input logic [1:0] k);
      look(n);
      check("status_code", code, c);
      check("status_class", {6'h00, cls}, {6'h00, k});
   endtask : see_st

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic do_ack(input logic [1:0] s);
      int n;
      logic w;
      n = 0;
      w = 1'b0;
      cyc(1);
      src <= s;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      do begin
         look(1);
         n++;
         if (n == 6) w = rwait;
      end while (creset !== 1'b1 && n < 200);
      check("reset_wait", {7'h00, w}, 8'h01);
      check("prot_time", {7'h00, n >= PR * TK}, 8'h01);
      check("latched", {7'h00, latched}, 8'h00);
      look(1);
      check("ctrl_reset", {7'h00, creset}, 8'h00);
   endtask : do_ack

   task automatic learn(input logic ok, input logic err);
      cyc(1);
      learn_run <= 1'b1;
      learn_ok <= ok;
      learn_err <= err;
      cyc(4);
      learn_ok <= 1'b0;
      learn_err <= 1'b0;
      learn_run <= 1'b0;
   endtask : learn

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic t_faults;
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         hw_fault <= 10'h001 << i;
         hold_ext <= 1'b1;
         obstruct <= 1'b1;
         see_st(6, door_fault_pkg::FAULT_CODE[i == 0 ? 0 : i + 2],
                door_fault_pkg::CLS_FAULT);
         cyc(1);
         hw_fault <= 10'h000;
         look(6);
         check("held", {7'h00, latched}, 8'h01);
         do_ack(2'(i % 3));
         see_st(2, door_fault_pkg::CODE_4,
                door_fault_pkg::CLS_ALARM);
      end
      cyc(1);
      hold_ext <= 1'b0;
      obstruct <= 1'b0;
      $display("test faults done");
   endtask : t_faults

   task automatic t_move;
      // sixteen cycles are at most four ticks: not strictly longer
      cyc(1);
      move <= 1'b1;
      cyc(MV * TK - 4);
      move <= 1'b0;
      see_st(8, door_fault_pkg::CODE_OK, door_fault_pkg::CLS_OK);
      cyc(1);
      move <= 1'b1;
      cyc((MV + 2) * TK);
      move <= 1'b0;
      see_st(6, door_fault_pkg::CODE_4, door_fault_pkg::CLS_FAULT);
      // a function block under another function must not acknowledge
      cyc(1);
      src <= 2'h3;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      look(8);
      check("wrong_fn_wait", {7'h00, rwait}, 8'h00);
      check("wrong_fn_held", {7'h00, latched}, 8'h01);
      do_ack(2'h0);
      $display("test move done");
   endtask : t_move

   task automatic t_alarms;
      cyc(1);
      obstruct <= 1'b1;
      see_st(6, door_fault_pkg::CODE_6, door_fault_pkg::CLS_INFO);
      cyc(1);
      hold_ext <= 1'b1;
      see_st(6, door_fault_pkg::CODE_4,
             door_fault_pkg::CLS_ALARM);
      cyc(1);
      hold_ext <= 1'b0;
      comm_to <= 1'b1;
      see_st(6, door_fault_pkg::CODE_Y,
             door_fault_pkg::CLS_ALARM);
      cyc(1);
      comm_to <= 1'b0;
      see_st(6, door_fault_pkg::CODE_6, door_fault_pkg::CLS_INFO);
      cyc(1);
      params_valid <= 1'b0;
      see_st(6, door_fault_pkg::CODE_NOPAR,
             door_fault_pkg::CLS_ALARM);
      cyc(1);
      params_valid <= 1'b1;
      learn_err <= 1'b1;
      cyc(4);
      learn_err <= 1'b0;
      see_st(6, door_fault_pkg::CODE_6, door_fault_pkg::CLS_INFO);
      learn(1'b0, 1'b1);
      see_st(8, door_fault_pkg::CODE_P,
             door_fault_pkg::CLS_ALARM);
      learn(1'b0, 1'b0);
      see_st(8, door_fault_pkg::CODE_6, door_fault_pkg::CLS_INFO);
      for (int b = 0; b < 2; b++) begin
         cyc(1);
         disc_err <= 2'h1 << b;
         blk_zero <= b == 0 ? 4'h5 : 4'h0;
         blk_two <= b == 1 ? 4'h3 : 4'h0;
         see_st(6, door_fault_pkg::CODE_A,
                door_fault_pkg::CLS_ALARM);
         cyc(1);
         disc_err <= 2'h0;
         see_st(6, door_fault_pkg::CODE_A,
                door_fault_pkg::CLS_ALARM);
         cyc(1);
         blk_zero <= b == 0 ? 4'hf : 4'h0;
         blk_two <= 4'h0;
         see_st(6, door_fault_pkg::CODE_6,
                door_fault_pkg::CLS_INFO);
      end
      cyc(1);
      obstruct <= 1'b0;
      see_st(6, door_fault_pkg::CODE_OK, door_fault_pkg::CLS_OK);
      $display("test alarms done");
   endtask : t_alarms

   task automatic t_motor;
      cyc(1);
      nv_valid <= 1'b0;
      resetn_i <= 1'b0;
      cyc(3);
      resetn_i <= 1'b1;
      see_st(10, door_fault_pkg::CODE_5,
             door_fault_pkg::CLS_FAULT);
      learn(1'b1, 1'b0);
      see_st(8, door_fault_pkg::CODE_5,
             door_fault_pkg::CLS_FAULT);
      do_ack(2'h1);
      see_st(4, door_fault_pkg::CODE_OK, door_fault_pkg::CLS_OK);
      cyc(1);
      motor_type <= 4'h9;
      see_st(6, door_fault_pkg::CODE_5,
             door_fault_pkg::CLS_ALARM);
      learn(1'b1, 1'b0);
      see_st(8, door_fault_pkg::CODE_OK, door_fault_pkg::CLS_OK);
      $display("test motor done");
   endtask : t_motor

   // -------------------------------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------------------------------
   initial begin
      {move, learn_run, learn_ok, learn_err, hold_ext} = 5'h00;
      {comm_to, obstruct, go} = 3'h0;
      {nv_valid, params_valid} = 2'h3;
      motor_type = 4'h2;
      nv_type = 4'h2;
      {blk_zero, blk_two} = 8'h00;
      {hw_fault, disc_err, src} = 14'h0000;
      cyc(3);
      resetn_i <= 1'b1;
      see_st(6, door_fault_pkg::CODE_OK, door_fault_pkg::CLS_OK);
      $display("test reset done");
      t_faults();
      t_move();
      t_alarms();
      t_motor();
      test_done();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk_i);
      fail_count++;
      $display("BAD watchdog expected done seen hang");
      test_done();
   end
endmodule : door_fault_mgr_bench
`default_nettype wire
